// ===== design/txstat_pkg.sv
// package: register map, phase and condition codes, carriers for the
// wireless transmitter status bank.
// assumes a single 20 MHz system clock and an i2c host on scl/sda pins.
// Summary of operation
// - in ping, power coil; on good strength packet go to identification, power on.
// - negotiation may alter contract; receiver checks no foreign object reported.
// - calibration supplies receiver data improving later foreign object checks; here only a cal_done flag is kept, and no check uses it.
// - power transfer is entered only after identification and configuration complete.
// - transfer is steered by control error, received power and end packets; received power packets are ignored here.
// - an end-of-transfer packet stops power delivery.
// - registers answer as i2c slave at default 7-bit address 0x61.
// - phase register resets 0 and uses the listed phase codes.
// - condition register resets 0 and uses the listed condition codes.
// - coil current mA, low byte 0x06e2, high byte 0x06e3.
// - coil voltage mV, low byte 0x06e4, high byte 0x06e5.
// - thermistor adc value, 16 bits, low then high byte.
// - switching period count, 16 bits; frequency is 60 MHz over count.
// - pulse width count, 16 bits; duty is count times 50% over 255.
// - bridge topology byte reads 0 half bridge, 1 full bridge.
// - after user data trigger, wait for end of next control error packet.
package txstat_pkg;
  localparam logic [6:0] I2C_ADDR_DEFAULT = 7'h61;
  localparam logic [15:0] OFS_PHASE = 16'h06e0;
  localparam logic [15:0] OFS_COND = 16'h06e1;
  localparam logic [15:0] OFS_AMPS_LO = 16'h06e2;
  localparam logic [15:0] OFS_AMPS_HI = 16'h06e3;
  localparam logic [15:0] OFS_VOLTS_LO = 16'h06e4;
  localparam logic [15:0] OFS_VOLTS_HI = 16'h06e5;
  localparam logic [15:0] OFS_TEMP_LO = 16'h06e8;
  localparam logic [15:0] OFS_TEMP_HI = 16'h06e9;
  localparam logic [15:0] OFS_PER_LO = 16'h06ea;
  localparam logic [15:0] OFS_PER_HI = 16'h06eb;
  localparam logic [15:0] OFS_PW_LO = 16'h06ec;
  localparam logic [15:0] OFS_PW_HI = 16'h06ed;
  localparam logic [15:0] OFS_BRIDGE = 16'h06ee;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] UNMAPPED_BYTE = 8'h00;

  typedef enum logic [7:0] {
    PH_STARTUP = 8'h00,
    PH_IDLE = 8'h01,
    PH_ANALOG_PING = 8'h02,
    PH_DIGITAL_PING = 8'h04,
    PH_IDENT = 8'h05,
    PH_CONFIG = 8'h07,
    PH_XFER_INIT = 8'h08,
    PH_XFER = 8'h09,
    PH_REMOVE = 8'h0b,
    PH_RESTART = 8'h0c,
    PH_NEGOTIATE = 8'h0d
  } phase_t;

  typedef enum logic [7:0] {
    CD_NORMAL = 8'h00,
    CD_FOREIGN_OBJ = 8'h01,
    CD_CHARGED = 8'h02,
    CD_NO_RESPONSE = 8'h04,
    CD_INT_FAULT = 8'h05,
    CD_OVER_TEMP = 8'h06,
    CD_OVER_CURRENT = 8'h07,
    CD_RX_FAULT = 8'h09,
    CD_NEG_FAIL = 8'h0a
  } cond_t;

  // one-cycle packet strobes from the demodulator
  typedef struct packed {
    logic strength;
    logic ident;
    logic config_pkt;
    logic negotiate_req;
    logic negotiate_end;
    logic calib;
    logic control_error;
    logic received_power;
    logic end_transfer;
    logic [7:0] end_reason;
  } packet_ev_t;

  // one-cycle fault and environment events
  typedef struct packed {
    logic object_present;
    logic object_removed;
    logic foreign_object;
    logic over_temp;
    logic over_current;
    logic internal_fault;
    logic no_response;
    logic negotiation_fail;
  } fault_ev_t;

  typedef struct packed {
    logic [15:0] coil_amps;
    logic [15:0] coil_volts;
    logic [15:0] temp_sense;
    logic [15:0] switching_period_count;
    logic [15:0] pulse_width_count;
    logic full_bridge;
  } telemetry_t;
endpackage

// ===== design/txstat_i2c_slave.sv
// i2c slave byte engine: address match, byte strobes, read data shifting.
// assumes scl/sda already synchronised by the caller; sda is open drain.
module txstat_i2c_slave
  import txstat_pkg::*;
#(
  parameter logic [6:0] ADDR = txstat_pkg::I2C_ADDR_DEFAULT
)
(
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic [7:0] i_rd_byte,
  output logic o_sda_oe,
  output logic o_wr_stb,
  output logic [7:0] o_wr_byte,
  output logic o_rd_stb,
  output logic o_start
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ADDR = 3'b001,
    S_ACK = 3'b010,
    S_WR = 3'b011,
    S_RD = 3'b100,
    S_RACK = 3'b101
  } sl_state_t;

  typedef struct packed {
    sl_state_t st;
    logic scl_d;
    logic sda_d;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic rw;
    logic oe;
    logic wr_stb;
    logic rd_stb;
    logic start;
  } sl_t;

  sl_t s_reg;
  sl_t s_next;
  logic rise;
  logic fall;

  assign rise = i_scl & ~s_reg.scl_d;
  assign fall = ~i_scl & s_reg.scl_d;

  always_comb
  begin
    s_next = s_reg;
    s_next.scl_d = i_scl;
    s_next.sda_d = i_sda;
    s_next.wr_stb = 1'b0;
    s_next.rd_stb = 1'b0;
    s_next.start = 1'b0;
    if (i_scl && s_reg.scl_d && s_reg.sda_d && !i_sda)
    begin
      s_next.st = S_ADDR;
      s_next.cnt = 4'h0;
      s_next.oe = 1'b0;
      s_next.start = 1'b1;
    end
    else if (i_scl && s_reg.scl_d && !s_reg.sda_d && i_sda)
    begin
      s_next.st = S_IDLE;
      s_next.oe = 1'b0;
    end
    else
    begin
      case (s_reg.st)
        S_IDLE: s_next.oe = 1'b0;
        S_ADDR, S_WR:
        begin
          if (rise)
          begin
            s_next.sh = {s_reg.sh[6:0], i_sda};
            s_next.cnt = s_reg.cnt + 4'h1;
          end
          if (fall && s_reg.cnt == 4'h8)
          begin
            s_next.cnt = 4'h0;
            if (s_reg.st == S_ADDR)
            begin
              if (s_reg.sh[7:1] == ADDR)
              begin
                s_next.rw = s_reg.sh[0];
                s_next.oe = 1'b1;
                s_next.st = S_ACK;
              end
              else
                s_next.st = S_IDLE;
            end
            else
            begin
              s_next.wr_stb = 1'b1;
              s_next.oe = 1'b1;
              s_next.st = S_ACK;
            end
          end
        end
        S_ACK:
          if (fall)
          begin
            if (s_reg.rw)
            begin
              s_next.sh = i_rd_byte;
              s_next.rd_stb = 1'b1;
              s_next.oe = ~i_rd_byte[7];
              s_next.cnt = 4'h1;
              s_next.st = S_RD;
            end
            else
            begin
              s_next.oe = 1'b0;
              s_next.st = S_WR;
            end
          end
        S_RD:
          if (fall)
          begin
            if (s_reg.cnt == 4'h8)
            begin
              s_next.oe = 1'b0;
              s_next.st = S_RACK;
            end
            else
            begin
              s_next.sh = {s_reg.sh[6:0], 1'b0};
              s_next.oe = ~s_reg.sh[6];
              s_next.cnt = s_reg.cnt + 4'h1;
            end
          end
        S_RACK:
          if (rise)
            s_next.st = i_sda ? S_IDLE : S_ACK;
        default: s_next.st = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
      s_reg <= '{st: S_IDLE, scl_d: 1'b1, sda_d: 1'b1, default: '0};
    else
      s_reg <= s_next;
  end

  assign o_sda_oe = s_reg.oe;
  assign o_wr_stb = s_reg.wr_stb;
  assign o_wr_byte = s_reg.sh;
  assign o_rd_stb = s_reg.rd_stb;
  assign o_start = s_reg.start;

  slave_start_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_arst_n)
    o_start |=> s_reg.st == S_ADDR)
    else $error("start not followed by address phase");
endmodule

// ===== design/txstat_phase_seq.sv
// protocol phase sequencer: ping, identification, configuration,
// negotiation, calibration, transfer; reports phase and condition.
// assumes one-cycle packet and fault strobes on the system clock.
module txstat_phase_seq
  import txstat_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire txstat_pkg::packet_ev_t i_pkt,
  input wire txstat_pkg::fault_ev_t i_flt,
  input wire logic i_user_trigger,
  output txstat_pkg::phase_t o_phase,
  output txstat_pkg::cond_t o_cond,
  output logic o_power_on,
  output logic o_user_send,
  output logic o_user_pending
);
  typedef struct packed {
    phase_t ph;
    cond_t cd;
    logic pwr;
    logic cal_done;
    logic pend;
    logic send;
  } seq_t;

  seq_t q_reg;
  seq_t q_next;
  logic fault_any;

  assign fault_any = i_flt.foreign_object | i_flt.over_temp |
    i_flt.over_current | i_flt.internal_fault | i_flt.no_response;

  always_comb
  begin
    q_next = q_reg;
    q_next.send = 1'b0;
    if (i_user_trigger)
      q_next.pend = 1'b1;
    case (q_reg.ph)
      PH_STARTUP: q_next.ph = PH_IDLE;
      PH_IDLE:
        if (i_flt.object_present)
          q_next.ph = PH_ANALOG_PING;
      PH_ANALOG_PING:
      begin
        q_next.ph = i_flt.object_removed ? PH_IDLE : PH_DIGITAL_PING;
        // power already on for the whole digital ping
        q_next.pwr = !i_flt.object_removed;
      end
      PH_DIGITAL_PING:
      begin
        q_next.pwr = 1'b1;
        if (i_pkt.strength)
          q_next.ph = PH_IDENT;
      end
      PH_IDENT:
        if (i_pkt.ident)
          q_next.ph = PH_CONFIG;
      PH_CONFIG:
        if (i_pkt.config_pkt)
          q_next.ph = i_pkt.negotiate_req ? PH_NEGOTIATE : PH_XFER_INIT;
      PH_NEGOTIATE:
        if (i_flt.negotiation_fail)
        begin
          q_next.cd = CD_NEG_FAIL;
          q_next.ph = PH_REMOVE;
        end
        else if (i_pkt.negotiate_end)
          q_next.ph = PH_XFER_INIT;
      PH_XFER_INIT:
      begin
        if (i_pkt.calib)
          q_next.cal_done = 1'b1;
        if (i_pkt.control_error)
          q_next.ph = PH_XFER;
      end
      PH_XFER:
      begin
        if (i_pkt.end_transfer)
        begin
          q_next.pwr = 1'b0;
          q_next.cd = cond_t'(i_pkt.end_reason);
          q_next.ph = PH_REMOVE;
        end
        else if (i_pkt.control_error && q_reg.pend)
        begin
          q_next.send = 1'b1;
          q_next.pend = i_user_trigger;
        end
      end
      PH_REMOVE:
      begin
        q_next.pwr = 1'b0;
        q_next.ph = PH_RESTART;
      end
      PH_RESTART:
        if (i_flt.object_removed)
        begin
          q_next.ph = PH_IDLE;
          q_next.cd = CD_NORMAL;
          q_next.cal_done = 1'b0;
        end
      default: q_next.ph = PH_STARTUP;
    endcase
    if (fault_any && q_reg.ph != PH_STARTUP && q_reg.ph != PH_IDLE &&
      q_reg.ph != PH_RESTART)
    begin
      q_next.pwr = 1'b0;
      q_next.ph = PH_REMOVE;
      q_next.cd = i_flt.over_current ? CD_OVER_CURRENT :
        i_flt.over_temp ? CD_OVER_TEMP :
        i_flt.foreign_object ? CD_FOREIGN_OBJ :
        i_flt.internal_fault ? CD_INT_FAULT : CD_NO_RESPONSE;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
      q_reg <= '{ph: PH_STARTUP, cd: CD_NORMAL, default: '0};
    else
      q_reg <= q_next;
  end

  assign o_phase = q_reg.ph;
  assign o_cond = q_reg.cd;
  assign o_power_on = q_reg.pwr;
  assign o_user_send = q_reg.send;
  assign o_user_pending = q_reg.pend;

  ping_advance_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_arst_n)
    q_reg.ph == PH_DIGITAL_PING && i_pkt.strength && !fault_any
    |=> q_reg.ph == PH_IDENT && o_power_on)
    else $error("ping did not advance with power held");
  xfer_entry_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_arst_n)
    q_reg.ph == PH_XFER && $past(q_reg.ph) != PH_XFER
    |-> $past(q_reg.ph) == PH_XFER_INIT)
    else $error("transfer entered without completed setup");
  end_stop_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_arst_n)
    q_reg.ph == PH_XFER && i_pkt.end_transfer
    |=> !o_power_on ##1 !o_power_on)
    else $error("power still on after end packet");
  user_wait_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_arst_n)
    o_user_send |-> $past(i_pkt.control_error) && $past(q_reg.pend))
    else $error("user data sent without control error end");
  neg_check_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_arst_n)
    q_reg.ph == PH_NEGOTIATE && i_flt.foreign_object
    |=> q_reg.ph == PH_REMOVE && o_cond == CD_FOREIGN_OBJ)
    else $error("foreign object in negotiation not reported");
  xfer_ctrl_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_arst_n)
    q_reg.ph == PH_XFER && !i_pkt.end_transfer && !fault_any
    |=> q_reg.ph == PH_XFER)
    else $error("transfer left without end packet or fault");
  reset_codes_a: assert property (@(posedge i_clk_sys)
    $rose(i_arst_n) |-> o_cond == CD_NORMAL)
    else $error("condition not normal after reset");
  cal_keep_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_arst_n)
    q_reg.ph == PH_XFER_INIT && i_pkt.calib |=> q_reg.cal_done)
    else $error("calibration data not kept");

  xfer_seen_c: cover property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    q_reg.ph == PH_XFER_INIT ##1 q_reg.ph == PH_XFER);
  end_seen_c: cover property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    q_reg.ph == PH_XFER ##1 q_reg.ph == PH_REMOVE);
  send_seen_c: cover property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    o_user_send);
endmodule

// ===== design/txstat_bank.sv
// top: i2c-reachable read-only status and telemetry bank of the
// wireless power transmitter, with its phase sequencer.
// assumes scl/sda from pins (resynchronised here) and telemetry and
// packet strobes on the system clock.
module txstat_bank
  import txstat_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = txstat_pkg::I2C_ADDR_DEFAULT
)
(
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_oe,
  input wire txstat_pkg::packet_ev_t i_pkt,
  input wire txstat_pkg::fault_ev_t i_flt,
  input wire txstat_pkg::telemetry_t i_tel,
  input wire logic i_tel_valid,
  input wire logic i_user_trigger,
  output logic o_power_on,
  output logic o_user_send,
  output logic o_user_pending,
  output txstat_pkg::phase_t o_phase
);
  // ---------------------------------------------------------------
  // pin synchronisers and bank state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [15:0] ptr;
    logic [1:0] wcnt;
    logic hold;
    telemetry_t snap;
  } bank_t;

  bank_t b_reg;
  bank_t b_next;
  logic wr_stb;
  logic [7:0] wr_byte;
  logic rd_stb;
  logic start;
  logic [7:0] rd_byte;
  phase_t phase;
  cond_t cond;

  // ---------------------------------------------------------------
  // read decode
  // ---------------------------------------------------------------
  function automatic logic [7:0] read_map(input logic [15:0] a,
    input phase_t p, input cond_t c, input telemetry_t t);
    logic [7:0] r;
    r = UNMAPPED_BYTE;
    case (a)
      OFS_PHASE: r = p;
      OFS_COND: r = c;
      OFS_AMPS_LO: r = t.coil_amps[7:0];
      OFS_AMPS_HI: r = t.coil_amps[15:8];
      OFS_VOLTS_LO: r = t.coil_volts[7:0];
      OFS_VOLTS_HI: r = t.coil_volts[15:8];
      OFS_TEMP_LO: r = t.temp_sense[7:0];
      OFS_TEMP_HI: r = t.temp_sense[15:8];
      OFS_PER_LO: r = t.switching_period_count[7:0];
      OFS_PER_HI: r = t.switching_period_count[15:8];
      OFS_PW_LO: r = t.pulse_width_count[7:0];
      OFS_PW_HI: r = t.pulse_width_count[15:8];
      OFS_BRIDGE: r = {7'h00, t.full_bridge};
      default: r = UNMAPPED_BYTE;
    endcase
    return r;
  endfunction

  function automatic logic is_low_byte(input logic [15:0] a);
    return a == OFS_AMPS_LO || a == OFS_VOLTS_LO || a == OFS_TEMP_LO ||
      a == OFS_PER_LO || a == OFS_PW_LO;
  endfunction

  assign rd_byte = read_map(b_reg.ptr, phase, cond, b_reg.snap);

  // ---------------------------------------------------------------
  // pointer and snapshot
  // ---------------------------------------------------------------
  always_comb
  begin
    b_next = b_reg;
    b_next.scl_sync = {b_reg.scl_sync[0], i_scl};
    b_next.sda_sync = {b_reg.sda_sync[0], i_sda};
    if (start)
      b_next.wcnt = 2'b00;
    // frozen from a low-byte pointer or read until the next other read;
    // a low byte read alone stays frozen until the next read or pointer write
    if (i_tel_valid && !b_reg.hold && !(rd_stb && is_low_byte(b_reg.ptr)))
      b_next.snap = i_tel;
    if (wr_stb)
    begin
      // address bytes set the pointer; data bytes are dropped but advance it
      case (b_reg.wcnt)
        2'b00:
        begin
          b_next.ptr[15:8] = wr_byte;
          b_next.wcnt = 2'b01;
        end
        2'b01:
        begin
          b_next.ptr[7:0] = wr_byte;
          b_next.wcnt = 2'b10;
          b_next.hold = is_low_byte({b_reg.ptr[15:8], wr_byte});
        end
        default:
        begin
          b_next.ptr = b_reg.ptr + 16'h0001;
          b_next.wcnt = 2'b11;
        end
      endcase
    end
    if (rd_stb)
    begin
      b_next.ptr = b_reg.ptr + 16'h0001;
      b_next.wcnt = 2'b11;
      b_next.hold = is_low_byte(b_reg.ptr);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
      b_reg <= '{scl_sync: 2'b11, sda_sync: 2'b11, default: '0};
    else
      b_reg <= b_next;
  end

  // ---------------------------------------------------------------
  // submodules
  // ---------------------------------------------------------------
  txstat_i2c_slave #(
    .ADDR(SLAVE_ADDR)
  ) u_slave (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_scl(b_reg.scl_sync[1]),
    .i_sda(b_reg.sda_sync[1]),
    .i_rd_byte(rd_byte),
    .o_sda_oe(o_sda_oe),
    .o_wr_stb(wr_stb),
    .o_wr_byte(wr_byte),
    .o_rd_stb(rd_stb),
    .o_start(start)
  );

  txstat_phase_seq u_seq (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_pkt(i_pkt),
    .i_flt(i_flt),
    .i_user_trigger(i_user_trigger),
    .o_phase(phase),
    .o_cond(cond),
    .o_power_on(o_power_on),
    .o_user_send(o_user_send),
    .o_user_pending(o_user_pending)
  );

  assign o_phase = phase;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  snap_hold_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_arst_n)
    rd_stb && is_low_byte(b_reg.ptr) |=> $stable(b_reg.snap))
    else $error("snapshot changed between byte reads");
  ro_write_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_arst_n)
    wr_stb && b_reg.wcnt == 2'b11 |=> $stable(phase) || $past(i_pkt) != '0
    || $past(i_flt) != '0)
    else $error("write disturbed read-only state");
  bridge_read_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_arst_n)
    b_reg.ptr == OFS_BRIDGE |-> rd_byte[7:1] == 7'h00)
    else $error("bridge byte has upper bits set");
  amps_map_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_arst_n)
    b_reg.ptr == OFS_AMPS_HI |-> rd_byte == b_reg.snap.coil_amps[15:8])
    else $error("coil current high byte wrong");
  snap_freeze_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_arst_n)
    b_reg.hold |=> $stable(b_reg.snap))
    else $error("snapshot moved while frozen");
  read_seen_c: cover property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    rd_stb && b_reg.ptr == OFS_PHASE);
  pair_seen_c: cover property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    rd_stb && b_reg.ptr == OFS_VOLTS_LO);
endmodule

// ===== verif/txstat_i2c_host.sv
// i2c host model: open-drain master, bit time 20 system clocks.
// assumes the bench resolves sda from this pull-down and the device's.
module txstat_i2c_host
(
  input wire logic i_clk_sys,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // every change lands just after a clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    #5;
  endtask
  task automatic bit_io(input logic b, output logic r);
    o_sda_low = ~b;
    tick(5);
    o_scl = 1'b1;
    tick(5);
    r = i_sda;
    tick(5);
    o_scl = 1'b0;
    tick(5);
  endtask
  // also serves as repeated start
  task automatic start();
    o_scl = 1'b0;
    o_sda_low = 1'b0;
    tick(5);
    o_scl = 1'b1;
    tick(5);
    o_sda_low = 1'b1;
    tick(5);
    o_scl = 1'b0;
    tick(5);
  endtask
  task automatic stop();
    o_sda_low = 1'b1;
    tick(5);
    o_scl = 1'b1;
    tick(5);
    o_sda_low = 1'b0;
    tick(5);
  endtask
  // q[8:1] bits seen on the wire, q[0] the ninth bit
  task automatic xb(input logic [7:0] d, input logic a,
                    output logic [8:0] q);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i + 1]);
    bit_io(a, q[0]);
  endtask
endmodule

// ===== verif/txstat_bank_tb.sv
// bench for the transmitter status bank: i2c host model, packet strobes
// and random telemetry; assumes the package constants and 20 MHz clock.
`define CHK(nm, e, g) \
  begin \
    n_checks++; \
    if ((g) !== (e)) \
    begin \
      err_total++; \
      $display("[FAIL] %s exp %h got %h", nm, e, g); \
    end \
  end
module txstat_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import txstat_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic scl, sda_low, sda_oe, sda, power_on, user_send, user_pending;
  packet_ev_t pkt = '0;
  fault_ev_t flt = '0;
  telemetry_t tel = '0;
  logic tel_valid = 1'b0;
  logic trig = 1'b0;
  phase_t phase;
  int err_total = 0;
  int n_checks = 0;
  int n_send = 0;
  int seed = 32'hdf7e;
  logic [8:0] q;
  logic [7:0] rbuf [16];
  cond_t rsn_list [5] = '{CD_CHARGED, CD_NO_RESPONSE, CD_INT_FAULT,
                          CD_RX_FAULT, CD_NEG_FAIL};
  assign sda = ~(sda_oe | sda_low);
  always #25 clk = ~clk;
  always @(posedge clk)
    if (user_send === 1'b1)
      n_send++;
  txstat_bank u_txstat_bank (
    .i_clk_sys(clk), .i_arst_n(arst_n), .i_scl(scl), .i_sda(sda),
    .o_sda_oe(sda_oe), .i_pkt(pkt), .i_flt(flt), .i_tel(tel),
    .i_tel_valid(tel_valid), .i_user_trigger(trig),
    .o_power_on(power_on), .o_user_send(user_send),
    .o_user_pending(user_pending), .o_phase(phase)
  );
  txstat_i2c_host u_txstat_i2c_host (
    .i_clk_sys(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low)
  );
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (100000) @(posedge clk);
    err_total++;
    finish_test();
  end
  task automatic waitph(input phase_t e);
    for (int k = 0; k < 8 && phase !== e; k++)
    begin
      @(posedge clk);
      #5;
    end
    `CHK("phase", e, phase)
    if (phase !== e)
      finish_test();
  endtask
  task automatic step(input logic [16:0] m, input logic [7:0] f);
    @(posedge clk);
    #5;
    pkt = packet_ev_t'(m);
    flt = fault_ev_t'(f);
    @(posedge clk);
    #5;
    pkt = '0;
    flt = '0;
  endtask
  task automatic set_ptr(input logic [6:0] dev, input logic [15:0] a);
    u_txstat_i2c_host.start();
    u_txstat_i2c_host.xb({dev, 1'b0}, 1'b1, q);
    `CHK("addr ack", dev == I2C_ADDR_DEFAULT, ~q[0])
    u_txstat_i2c_host.xb(a[15:8], 1'b1, q);
    u_txstat_i2c_host.xb(a[7:0], 1'b1, q);
  endtask
  task automatic rd(input logic [15:0] a, input int n);
    set_ptr(I2C_ADDR_DEFAULT, a);
    u_txstat_i2c_host.start();
    u_txstat_i2c_host.xb({I2C_ADDR_DEFAULT, 1'b1}, 1'b1, q);
    for (int i = 0; i < n; i++)
    begin
      u_txstat_i2c_host.xb(8'hff, i == n - 1, q);
      rbuf[i] = q[8:1];
    end
    u_txstat_i2c_host.stop();
  endtask
  function automatic logic [7:0] exp_tel(input telemetry_t t, input int i);
    case (i)
      2: return t.coil_amps[7:0];
      3: return t.coil_amps[15:8];
      4: return t.coil_volts[7:0];
      5: return t.coil_volts[15:8];
      8: return t.temp_sense[7:0];
      9: return t.temp_sense[15:8];
      10: return t.switching_period_count[7:0];
      11: return t.switching_period_count[15:8];
      12: return t.pulse_width_count[7:0];
      13: return t.pulse_width_count[15:8];
      14: return {7'h00, t.full_bridge};
      default: return UNMAPPED_BYTE;
    endcase
  endfunction
  function automatic telemetry_t rnd_tel();
    logic [95:0] r;
    r = {$random(seed), $random(seed), $random(seed)};
    return telemetry_t'(r[80:0]);
  endfunction
  // capture t, then move the inputs without a sample enable
  task automatic tel_case(input telemetry_t t);
    @(posedge clk);
    #5;
    tel = t;
    tel_valid = 1'b1;
    @(posedge clk);
    #5;
    tel_valid = 1'b0;
    tel = rnd_tel();
    rd(OFS_AMPS_LO, 13);
    for (int i = 0; i < 13; i++)
      `CHK("tel", exp_tel(t, i + 2), rbuf[i])
  endtask
  // telemetry keeps moving while one low/high pair is read
  task automatic pair_case(input telemetry_t t);
    @(posedge clk);
    #5;
    tel = t;
    tel_valid = 1'b1;
    fork
      rd(OFS_VOLTS_LO, 2);
      begin
        repeat (650) @(posedge clk);
        #5;
        tel = rnd_tel();
        repeat (200) @(posedge clk);
        #5;
        tel = rnd_tel();
      end
    join
    tel_valid = 1'b0;
    `CHK("pair lo", t.coil_volts[7:0], rbuf[0])
    `CHK("pair hi", t.coil_volts[15:8], rbuf[1])
  endtask
  task automatic walk(input cond_t rsn, input logic [7:0] f);
    int s;
    step(17'h00400, 8'h00);
    waitph(PH_IDLE);
    step(17'h00000, 8'h80);
    waitph(PH_DIGITAL_PING);
    `CHK("power ping", 1'b1, power_on)
    step(17'h00400, 8'h00);
    waitph(PH_DIGITAL_PING);
    step(17'h10000, 8'h00);
    waitph(PH_IDENT);
    `CHK("power ident", 1'b1, power_on)
    step(17'h08000, 8'h00);
    waitph(PH_CONFIG);
    step(17'h06000, 8'h00);
    waitph(PH_NEGOTIATE);
    if (f != 8'h00)
      step(17'h00000, f);
    else
    begin
      step(17'h01000, 8'h00);
      waitph(PH_XFER_INIT);
      step(17'h00c00, 8'h00);
      waitph(PH_XFER);
      step(17'h00200, 8'h00);
      waitph(PH_XFER);
      trig = 1'b1;
      @(posedge clk);
      #5;
      trig = 1'b0;
      `CHK("pending", 1'b1, user_pending)
      s = n_send;
      step(17'h00200, 8'h00);
      `CHK("early send", s, n_send)
      step(17'h00400, 8'h00);
      repeat (3) @(posedge clk);
      #5;
      `CHK("send count", s + 1, n_send)
      `CHK("pending clr", 1'b0, user_pending)
      step(17'h00100 | 17'(rsn), 8'h00);
    end
    waitph(PH_RESTART);
    `CHK("power end", 1'b0, power_on)
    rd(OFS_PHASE, 2);
    `CHK("phase rd", PH_RESTART, rbuf[0])
    `CHK("cond rd", rsn, rbuf[1])
    step(17'h00000, 8'h40);
    waitph(PH_IDLE);
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    #5;
    `CHK("reset phase", PH_STARTUP, phase)
    arst_n = 1'b1;
    waitph(PH_IDLE);
    tel_case('0);
    tel_case('1);
    repeat (4)
      tel_case(rnd_tel());
    pair_case(rnd_tel());
    set_ptr(7'h62, OFS_PHASE);
    u_txstat_i2c_host.stop();
    foreach (rsn_list[i])
      walk(rsn_list[i], 8'h00);
    walk(CD_FOREIGN_OBJ, 8'h20);
    walk(CD_OVER_CURRENT, 8'h18);
    walk(CD_NEG_FAIL, 8'h01);
    set_ptr(I2C_ADDR_DEFAULT, OFS_PHASE);
    u_txstat_i2c_host.xb(8'hff, 1'b1, q);
    u_txstat_i2c_host.xb(8'h5a, 1'b1, q);
    u_txstat_i2c_host.stop();
    rd(OFS_PHASE, 2);
    `CHK("phase ro", PH_IDLE, rbuf[0])
    `CHK("cond ro", CD_NORMAL, rbuf[1])
    finish_test();
  end
endmodule
